/* dv/tb_top.sv */
// ==========================================================
// self-checking bench for the call / clear / complement execution unit
// assumes one clock per phase and drives instruction words on the ports directly
`timescale 1ns/1ps
module tb_top
  import cce_pkg::*;
;
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [15:0] instr_i = 16'h0000;
  logic [15:0] instr2_i = 16'h0000;
  logic [3:0] bank = 4'h0;
  logic [11:0] fsr2 = 12'h000;
  logic ext_en = 1'b0;
  logic [7:0] rdata = 8'h00;
  logic [1:0] phase_o;
  logic cycle_start_o, stack_push_o, mem_rd_o, mem_we_o, watchdog_clear_o;
  logic [PC_W-1:0] pc_o, return_stack_top_o;
  logic [DADDR_W-1:0] mem_addr_o;
  logic [7:0] mem_wdata_o, w_o, working_shadow_o;
  logic [STAT_W-1:0] status_o, status_shadow_o;
  logic [3:0] bank_select_shadow_o;
  logic timeout_flag_n_o, powerdown_flag_n_o;
  int miscompares = 0;
  int n_checks = 0;
  int exp_wait = 0;
  logic [25:0] notes[$];
  logic [25:0] got, exp_note;
  logic [1:0] ph;
  logic [PC_W-1:0] m_pc = 21'h000000;
  logic [7:0] m_w = 8'h00, m_w_shd = 8'h00;
  logic [4:0] m_st = 5'h00, m_ss = 5'h00;
  logic [3:0] m_bs = 4'h0;

  always #12.5 ref_clk_i = ~ref_clk_i;

  cce_exec dut_u (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .instr_i(instr_i),
    .instr2_i(instr2_i), .bank_select_register_i(bank), .fsr2_i(fsr2),
    .ext_instr_en_i(ext_en), .mem_rdata_i(rdata), .phase_o(phase_o),
    .cycle_start_o(cycle_start_o), .pc_o(pc_o), .stack_push_o(stack_push_o),
    .return_stack_top_o(return_stack_top_o), .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o),
    .mem_we_o(mem_we_o), .mem_wdata_o(mem_wdata_o), .w_o(w_o), .status_o(status_o),
    .working_shadow_o(working_shadow_o), .status_shadow_o(status_shadow_o),
    .bank_select_shadow_o(bank_select_shadow_o), .watchdog_clear_o(watchdog_clear_o),
    .timeout_flag_n_o(timeout_flag_n_o), .powerdown_flag_n_o(powerdown_flag_n_o));

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out

  task automatic check(input logic [47:0] seen, input logic [47:0] exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  // ==========================================================
  // driver: waits for a decode phase, checks state, issues one word pair
  task automatic issue(input logic [15:0] i1, input logic [15:0] i2, input logic [3:0] b,
                       input logic [11:0] x, input logic e, input logic [7:0] rd);
    int n;
    n = 0;
    while (!(phase_o === PH_Q1 && cycle_start_o === 1'b1)) begin
      @(posedge ref_clk_i);
      #1;
      n++;
      if (n > 20) begin
        miscompares++;
        close_out();
      end
    end
    check(n, exp_wait, "cycle length");
    check({pc_o, w_o, status_o}, {m_pc, m_w, m_st}, "pc w status");
    check({working_shadow_o, status_shadow_o, bank_select_shadow_o}, {m_w_shd, m_ss, m_bs},
      "shadows");
    check({timeout_flag_n_o, powerdown_flag_n_o}, 2'b11, "flags");
    // a call holds off the next start for seven clocks, any other word for three
    exp_wait = (i1[15:9] == 7'h76 && i2[15:12] == 4'hf) ? 7 : 3;
    instr_i = i1;
    instr2_i = i2;
    bank = b;
    fsr2 = x;
    ext_en = e;
    rdata = rd;
    @(posedge ref_clk_i);
    #1;
  endtask : issue

  // ==========================================================
  // monitor: every write, push or watchdog-clear strobe takes the oldest note
  always @(negedge ref_clk_i) begin
    if (nrst_i === 1'b1 && (mem_we_o | stack_push_o | watchdog_clear_o) === 1'b1) begin
      if (mem_we_o === 1'b1) begin
        got = {2'd1, 4'h0, mem_addr_o, mem_wdata_o};
        ph = PH_Q4;
      end else if (stack_push_o === 1'b1) begin
        got = {2'd2, 3'h0, return_stack_top_o};
        ph = PH_Q3;
      end else begin
        got = {2'd3, 24'h0};
        ph = PH_Q3;
      end
      exp_note = (notes.size() > 0) ? notes.pop_front() : 26'h0;
      check(phase_o, ph, "strobe phase");
      check(got, exp_note, "strobe payload");
    end
    if (mem_rd_o === 1'b1) check(phase_o, PH_Q2, "read phase");
  end

  initial begin
    logic [31:0] r;
    logic [7:0] f, res, rd;
    logic [11:0] ea;
    logic a;
    r = 32'had64;
    repeat (16) @(posedge ref_clk_i);
    #1;
    nrst_i = 1'b1;
    for (int i = 0; i < 120; i++) begin
      r = lfsr_next(r);
      f = (i % 4 == 0) ? 8'h5f : (i % 4 == 1) ? 8'h60 : r[15:8];
      a = r[16];
      rd = (i % 14 == 8) ? 8'hff : r[29:22];
      if (a) ea = {r[21:18], f};
      else if (r[17] && f <= 8'h5f) ea = r[31:20] + {4'h0, f};
      else ea = {(f < 8'h60) ? 4'h0 : 4'hf, f};
      res = ~rd;
      case (i % 7)
        0, 5: begin
          notes.push_back({2'd1, 4'h0, ea, 8'h00});
          issue({7'h35, a, f}, 16'h0000, r[21:18], r[31:20], r[17], rd);
          m_st[STAT_Z] = 1'b1;
          m_pc = m_pc + 21'h2;
        end
        1, 2: begin
          if (i % 7 == 2) notes.push_back({2'd1, 4'h0, ea, res});
          issue({6'h07, i % 7 == 2, a, f}, 16'h0000, r[21:18], r[31:20], r[17], rd);
          if (i % 7 == 1) m_w = res;
          m_st[STAT_N] = res[7];
          m_st[STAT_Z] = (res == 8'h00);
          m_pc = m_pc + 21'h2;
        end
        3: begin
          notes.push_back({2'd3, 24'h0});
          issue(16'h0004, 16'h0000, r[21:18], r[31:20], r[17], rd);
          m_pc = m_pc + 21'h2;
        end
        4, 6: begin
          notes.push_back({2'd2, 3'h0, m_pc + 21'h4});
          issue({7'h76, a, r[31:24]}, {4'hf, r[23:12]}, r[21:18], r[31:20], r[17], rd);
          if (a) begin
            m_w_shd = m_w;
            m_ss = m_st;
            m_bs = r[21:18];
          end
          m_pc = {r[23:12], r[31:24], 1'b0};
        end
        default: ;
      endcase
    end
    issue(16'h0000, 16'h0000, 4'h0, 12'h000, 1'b0, 8'h00);
    check(notes.size(), 0, "notes left");
    close_out();
  end
endmodule : tb_top

/* rtl/cce_addr_gen.sv */
// data-memory address for file-register instructions
// assumes inputs are stable for the phase in which the address is taken
`timescale 1ns/1ps
module cce_addr_gen
  import cce_pkg::*;
(
  cce_addr_if.gen ai
);

  // ==========================================================
  // address select
  always_comb begin
    if (ai.acc) begin
      ai.addr = {ai.bank, ai.f};
    end else if (ai.ext_en && (ai.f <= ILO_MAX_F)) begin
      ai.addr = ai.fsr2 + {4'h0, ai.f};
    end else if (ai.f >= ACCESS_SPLIT) begin
      ai.addr = {ACCESS_HI_BANK, ai.f};
    end else begin
      ai.addr = {ACCESS_LO_BANK, ai.f};
    end
  end

endmodule : cce_addr_gen

/* rtl/cce_addr_if.sv */
// file-address request and answer between the executer and the address generator
// assumes both ends sit in the same clock domain
`timescale 1ns/1ps
interface cce_addr_if;
  logic [7:0] f;
  logic acc;
  logic [3:0] bank;
  logic [11:0] fsr2;
  logic ext_en;
  logic [11:0] addr;

  modport gen (input f, input acc, input bank, input fsr2, input ext_en, output addr);
  modport user (output f, output acc, output bank, output fsr2, output ext_en, input addr);
endinterface : cce_addr_if

/* rtl/cce_exec.sv */
// execution of call, clear-file, clear-watchdog and complement-file
// assumes instr_i and instr2_i hold the current and next program words during Q1
`timescale 1ns/1ps
module cce_exec
  import cce_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic [15:0] instr_i,
  input wire logic [15:0] instr2_i,
  input wire logic [3:0] bank_select_register_i,
  input wire logic [11:0] fsr2_i,
  input wire logic ext_instr_en_i,
  input wire logic [7:0] mem_rdata_i,
  output logic [1:0] phase_o,
  output logic cycle_start_o,
  output logic [PC_W-1:0] pc_o,
  output logic stack_push_o,
  output logic [PC_W-1:0] return_stack_top_o,
  output logic [DADDR_W-1:0] mem_addr_o,
  output logic mem_rd_o,
  output logic mem_we_o,
  output logic [7:0] mem_wdata_o,
  output logic [7:0] w_o,
  output logic [STAT_W-1:0] status_o,
  output logic [7:0] working_shadow_o,
  output logic [STAT_W-1:0] status_shadow_o,
  output logic [3:0] bank_select_shadow_o,
  output logic watchdog_clear_o,
  output logic timeout_flag_n_o,
  output logic powerdown_flag_n_o
);

  // ==========================================================
  // state
  cce_state_t state, next_state;
  logic [1:0] phase, next_phase;
  logic [15:0] ir, next_ir;
  logic [15:0] ir2, next_ir2;
  logic [7:0] lit_lo, next_lit_lo;
  logic [7:0] opnd, next_opnd;
  logic [7:0] wdata, next_wdata;
  logic [DADDR_W-1:0] addr, next_addr;
  logic [PC_W-1:0] pc, next_pc;
  logic [PC_W-1:0] ret, next_ret;
  logic [7:0] w, next_w;
  logic [STAT_W-1:0] stat, next_stat;
  logic [7:0] w_shd, next_w_shd;
  logic [STAT_W-1:0] ss, next_ss;
  logic [3:0] bs, next_bs;
  logic tmo_n, next_tmo_n;
  logic pwd_n, next_pwd_n;
  logic exec, is_call, is_clr_file, is_comp_file, is_clr_wdog;

  cce_addr_if ai();

  assign ai.f = instr_i[7:0];
  assign ai.acc = instr_i[ACC_BIT];
  assign ai.bank = bank_select_register_i;
  assign ai.fsr2 = fsr2_i;
  assign ai.ext_en = ext_instr_en_i;

  cce_addr_gen u_addr_gen (
    .ai(ai)
  );

  // ==========================================================
  // decode
  assign exec = (state == ST_EXEC);
  assign is_call = exec && (ir[15:9] == CALL_OP1) && (ir2[15:12] == CALL_OP2);
  assign is_clr_file = exec && (ir[15:9] == CLR_FILE_OP);
  assign is_comp_file = exec && (ir[15:10] == COMP_FILE_OP);
  assign is_clr_wdog = exec && (ir == CLR_WDOG_OP);

  // ==========================================================
  // next values
  always_comb begin
    next_state = state;
    next_phase = phase + 2'h1;
    next_ir = ir;
    next_ir2 = ir2;
    next_lit_lo = lit_lo;
    next_opnd = opnd;
    next_wdata = wdata;
    next_addr = addr;
    next_pc = pc;
    next_ret = ret;
    next_w = w;
    next_stat = stat;
    next_w_shd = w_shd;
    next_ss = ss;
    next_bs = bs;
    next_tmo_n = tmo_n;
    next_pwd_n = pwd_n;
    case (phase)
      PH_Q1: begin
        if (exec) begin
          next_ir = instr_i;
          next_ir2 = instr2_i;
          next_addr = ai.addr;
        end
      end
      PH_Q2: begin
        if (is_call) begin
          next_lit_lo = ir[7:0];
          next_ret = pc + PC_RET_OFS;
        end
        if (is_clr_file || is_comp_file) begin
          next_opnd = mem_rdata_i;
        end
      end
      PH_Q3: begin
        if (is_call && ir[CALL_S_BIT]) begin
          next_w_shd = w;
          next_ss = stat;
          next_bs = bank_select_register_i;
        end
        if (is_clr_file) begin
          next_wdata = CLR_VALUE;
        end
        if (is_comp_file) begin
          next_wdata = ~opnd;
        end
        if (is_clr_wdog) begin
          next_tmo_n = 1'b1;
          next_pwd_n = 1'b1;
        end
      end
      PH_Q4: begin
        if (is_call) begin
          next_pc = {ir2[11:0], lit_lo, 1'b0};
          next_state = ST_CALL2;
        end else if (exec) begin
          next_pc = pc + PC_STEP;
        end else begin
          next_state = ST_EXEC;
        end
        if (is_clr_file) begin
          next_stat[STAT_Z] = 1'b1;
        end
        if (is_comp_file) begin
          next_stat[STAT_N] = wdata[7];
          next_stat[STAT_Z] = (wdata == CLR_VALUE);
          // result to W when d clear
          if (!ir[DEST_BIT]) begin
            next_w = wdata;
          end
        end
      end
      default: next_phase = PH_Q1;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      state <= ST_EXEC;
      phase <= PH_Q1;
      ir <= 16'h0000;
      ir2 <= 16'h0000;
      lit_lo <= 8'h00;
      opnd <= 8'h00;
      wdata <= 8'h00;
      addr <= 12'h000;
      pc <= PC_RST;
      ret <= PC_RST;
      w <= W_RST;
      stat <= STAT_RST;
      w_shd <= W_RST;
      ss <= STAT_RST;
      bs <= 4'h0;
      tmo_n <= FLAG_RST;
      pwd_n <= FLAG_RST;
    end else begin
      state <= next_state;
      phase <= next_phase;
      ir <= next_ir;
      ir2 <= next_ir2;
      lit_lo <= next_lit_lo;
      opnd <= next_opnd;
      wdata <= next_wdata;
      addr <= next_addr;
      pc <= next_pc;
      ret <= next_ret;
      w <= next_w;
      stat <= next_stat;
      w_shd <= next_w_shd;
      ss <= next_ss;
      bs <= next_bs;
      tmo_n <= next_tmo_n;
      pwd_n <= next_pwd_n;
    end
  end

  // ==========================================================
  // outputs
  assign phase_o = phase;
  assign cycle_start_o = exec && (phase == PH_Q1);
  assign pc_o = pc;
  assign stack_push_o = is_call && (phase == PH_Q3);
  assign return_stack_top_o = ret;
  assign mem_addr_o = addr;
  assign mem_rd_o = (is_clr_file || is_comp_file) && (phase == PH_Q2);
  assign mem_we_o = (is_clr_file || (is_comp_file && ir[DEST_BIT])) && (phase == PH_Q4);
  assign mem_wdata_o = wdata;
  assign w_o = w;
  assign status_o = stat;
  assign working_shadow_o = w_shd;
  assign status_shadow_o = ss;
  assign bank_select_shadow_o = bs;
  assign watchdog_clear_o = is_clr_wdog && (phase == PH_Q3);
  assign timeout_flag_n_o = tmo_n;
  assign powerdown_flag_n_o = pwd_n;

  // ==========================================================
  // checks
  a_call_two_cycles: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (is_call && phase == PH_Q4) |=> (state == ST_CALL2) [*4] ##1 (state == ST_EXEC))
    else $error("call did not take exactly two cycles");
  a_push_address: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    stack_push_o |-> (return_stack_top_o == pc_o + PC_RET_OFS))
    else $error("pushed return address wrong");
  a_shadow_copy: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (stack_push_o && ir[CALL_S_BIT]) |=> (working_shadow_o == $past(w_o))
      && (status_shadow_o == $past(status_o))
      && (bank_select_shadow_o == $past(bank_select_register_i)))
    else $error("shadow registers not copied");
  a_shadow_hold: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (stack_push_o && !ir[CALL_S_BIT]) |=> $stable(working_shadow_o)
      && $stable(status_shadow_o) && $stable(bank_select_shadow_o))
    else $error("shadow registers changed with s clear");
  a_call_target: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (is_call && phase == PH_Q4) |=> (pc_o == {ir2[11:0], ir[7:0], 1'b0}))
    else $error("call target not loaded");
  a_clear_zero: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (is_clr_file && phase == PH_Q4) |-> mem_we_o && (mem_wdata_o == CLR_VALUE)
      ##1 status_o[STAT_Z])
    else $error("clear-file result or zero flag wrong");
  a_banked_addr: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (exec && phase == PH_Q1 && instr_i[ACC_BIT]) |=>
      (mem_addr_o == {$past(bank_select_register_i), ir[7:0]}))
    else $error("banked address wrong");
  a_indexed_addr: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (exec && phase == PH_Q1 && !instr_i[ACC_BIT] && ext_instr_en_i
      && instr_i[7:0] <= ILO_MAX_F) |=>
      (mem_addr_o == 12'($past(fsr2_i) + {4'h0, ir[7:0]})))
    else $error("indexed literal offset address wrong");
  a_wdog_flags: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    watchdog_clear_o |=> timeout_flag_n_o && powerdown_flag_n_o)
    else $error("watchdog flags not set");
  a_comp_value: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (is_comp_file && phase == PH_Q4) |-> (mem_wdata_o == ~opnd)
      ##1 (status_o[STAT_Z] == ($past(mem_wdata_o) == CLR_VALUE))
      && (status_o[STAT_N] == $past(mem_wdata_o[7])))
    else $error("complement result or flags wrong");
  a_comp_dest: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (is_comp_file && phase == PH_Q4) |-> (mem_we_o == ir[DEST_BIT])
      ##1 (ir[DEST_BIT] ? $stable(w_o) : (w_o == mem_wdata_o)))
    else $error("complement destination wrong");
  a_read_phase: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    mem_rd_o |-> (phase == PH_Q2) ##2 (mem_we_o == (is_clr_file || ir[DEST_BIT])))
    else $error("file access phase wrong");

endmodule : cce_exec

/* rtl/cce_pkg.sv */
// constants for the call / clear / complement execution unit
// assumes an 8-bit core with a 4-phase instruction cycle, one clock per phase
package cce_pkg;

  // ==========================================================
  // widths
  localparam int PC_W = 21;
  localparam int DADDR_W = 12;
  localparam int STAT_W = 5;

  // ==========================================================
  // opcode fields
  localparam logic [6:0] CALL_OP1 = 7'h76;
  localparam logic [3:0] CALL_OP2 = 4'hf;
  localparam logic [6:0] CLR_FILE_OP = 7'h35;
  localparam logic [5:0] COMP_FILE_OP = 6'h07;
  localparam logic [15:0] CLR_WDOG_OP = 16'h0004;
  localparam int CALL_S_BIT = 8;
  localparam int ACC_BIT = 8;
  localparam int DEST_BIT = 9;

  // ==========================================================
  // addressing
  localparam logic [7:0] ILO_MAX_F = 8'h5f;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
  localparam logic [3:0] ACCESS_LO_BANK = 4'h0;

  // ==========================================================
  // program counter and status
  localparam logic [PC_W-1:0] PC_RET_OFS = 21'h000004;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
  localparam logic [PC_W-1:0] PC_RST = 21'h000000;
  localparam int STAT_N = 4;
  localparam int STAT_Z = 2;
  localparam logic [STAT_W-1:0] STAT_RST = 5'h00;
  localparam logic [7:0] W_RST = 8'h00;
  localparam logic [7:0] CLR_VALUE = 8'h00;
  localparam logic FLAG_RST = 1'b1;

  // ==========================================================
  // phases of one instruction cycle
  localparam logic [1:0] PH_Q1 = 2'h0;
  localparam logic [1:0] PH_Q2 = 2'h1;
  localparam logic [1:0] PH_Q3 = 2'h2;
  localparam logic [1:0] PH_Q4 = 2'h3;

  typedef enum logic {
    ST_EXEC,
    ST_CALL2
  } cce_state_t;

endpackage : cce_pkg
